// *** include/cwc_pkg.sv ***
// Package for the complementary waveform control block: map, fields, modes, shutdown sources
`default_nettype none
package cwc_pkg;

  localparam int unsigned APB_AW = 8;
  localparam int unsigned APB_DW = 32;
  localparam int unsigned REG_W = 8;
  localparam int unsigned DB_W = 6;
  localparam int unsigned SD_W = 5;

  // Byte addresses of the registers
  localparam logic [APB_AW-1:0] OFS_CONTROL_0 = 8'h00;
  localparam logic [APB_AW-1:0] OFS_CONTROL_1 = 8'h04;
  localparam logic [APB_AW-1:0] OFS_CLOCK_SELECT = 8'h08;
  localparam logic [APB_AW-1:0] OFS_SHUTDOWN_EN = 8'h0c;
  localparam logic [APB_AW-1:0] OFS_RISING_DB = 8'h10;
  localparam logic [APB_AW-1:0] OFS_STEER_STATUS = 8'h14;

  // Field positions
  localparam int unsigned CON0_EN_BIT = 7;
  localparam int unsigned CON0_LD_BIT = 6;
  localparam int unsigned CON0_MODE_LSB = 0;
  localparam int unsigned CON1_IN_BIT = 5;
  localparam int unsigned CON1_POL_LSB = 0;
  localparam int unsigned CLK_CS_BIT = 0;
  localparam int unsigned AS_LSB = 0;
  localparam int unsigned DB_LSB = 0;
  localparam int unsigned STEER_LSB = 0;
  localparam int unsigned STAT_SD_BIT = 4;

  // Shutdown source positions
  localparam int unsigned SD_PIN = 0;
  localparam int unsigned SD_CMP1 = 1;
  localparam int unsigned SD_LOGIC4 = 4;

  // Reset values
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [3:0] NIBBLE_RST = 4'h0;
  localparam logic [SD_W-1:0] SD_RST = 5'h00;
  localparam logic [DB_W-1:0] DB_RST = 6'h00;
  localparam logic [REG_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [APB_DW-1:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    CWC_MODE_ASYNC_STEER = 3'h0,
    CWC_MODE_SYNC_STEER = 3'h1,
    CWC_MODE_FWD_FULL = 3'h2,
    CWC_MODE_REV_FULL = 3'h3,
    CWC_MODE_HALF_BRIDGE = 3'h4,
    CWC_MODE_PUSH_PULL = 3'h5,
    CWC_MODE_RSVD_6 = 3'h6,
    CWC_MODE_RSVD_7 = 3'h7
  } cwc_mode_type;

  // One bit per output channel, a in bit 0
  typedef struct packed {
    logic d;
    logic c;
    logic b;
    logic a;
  } cwc_quad_type;

  // Shutdown request lines in source order
  typedef struct packed {
    logic logic4;
    logic src3;
    logic src2;
    logic cmp1;
    logic pin;
  } cwc_sd_type;

  function automatic logic cwc_is_reg(input logic [APB_AW-1:0] addr);
    return (addr == OFS_CONTROL_0) || (addr == OFS_CONTROL_1) ||
           (addr == OFS_CLOCK_SELECT) || (addr == OFS_SHUTDOWN_EN) ||
           (addr == OFS_RISING_DB) || (addr == OFS_STEER_STATUS);
  endfunction : cwc_is_reg

  function automatic logic [APB_DW-1:0] cwc_word(input logic [REG_W-1:0] b);
    return {{(APB_DW-REG_W){1'b0}}, b};
  endfunction : cwc_word

endpackage : cwc_pkg
`default_nettype wire

// *** hdl/cwc_sync.sv ***
// Two-stage synchroniser for a group of pin-level inputs
`timescale 1ns/1ps
`default_nettype none
module cwc_sync
  import cwc_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  // First stage feeds only the second stage
  always_comb begin
    nxt_meta = meta_ff;
    nxt_sync = sync_ff;
    if (srst_i) begin
      nxt_meta = '0;
      nxt_sync = '0;
    end else if (ce_i) begin
      nxt_meta = async_i;
      nxt_sync = meta_ff;
    end
  end

  always_ff @(posedge core_clk_i) begin
    meta_ff <= nxt_meta;
    sync_ff <= nxt_sync;
  end

  assign sync_o = sync_ff;

endmodule : cwc_sync
`default_nettype wire

// *** hdl/cwc_deadband.sv ***
// Rising-edge dead-band delay counter
`timescale 1ns/1ps
`default_nettype none
module cwc_deadband
  import cwc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic data_i,
  input wire logic data_rise_i,
  input wire logic [DB_W-1:0] count_i,
  output logic delayed_o
);

  logic [DB_W-1:0] cnt_ff;
  logic [DB_W-1:0] nxt_cnt;
  logic busy_ff;
  logic nxt_busy;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_busy = busy_ff;
    if (srst_i) begin
      nxt_cnt = DB_RST;
      nxt_busy = 1'b0;
    end else if (ce_i) begin
      if (!data_i) begin
        nxt_busy = 1'b0;
      end else if (data_rise_i) begin
        nxt_cnt = count_i;
        nxt_busy = (count_i != DB_RST);
      end else if (busy_ff && tick_i) begin
        nxt_cnt = cnt_ff - 6'h01;
        nxt_busy = (cnt_ff != 6'h01);
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    cnt_ff <= nxt_cnt;
    busy_ff <= nxt_busy;
  end

  // Count of zero passes the edge with no added delay
  assign delayed_o = data_i && !busy_ff && !(data_rise_i && (count_i != DB_RST));

endmodule : cwc_deadband
`default_nettype wire

// *** hdl/cwc_top.sv ***
// Complementary waveform control: APB registers, mode steering, shutdown, polarity
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module cwc_top
  import cwc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [APB_AW-1:0] paddr_i,
  input wire logic [APB_DW-1:0] pwdata_i,
  output logic [APB_DW-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic fosc_tick_i,
  input wire logic internal_fast_oscillator_tick_i,
  input wire logic data_pin_i,
  input wire cwc_sd_type shutdown_req_i,
  output cwc_quad_type wave_o,
  output logic shutdown_o
);

  // Pin-level inputs are synchronised before use
  logic data_sync;
  cwc_sd_type sd_sync;

  cwc_sync #(
    .WIDTH(1)
  ) u_data_sync (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .async_i(data_pin_i),
    .sync_o(data_sync)
  );

  cwc_sync #(
    .WIDTH(SD_W)
  ) u_sd_sync (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .async_i(shutdown_req_i),
    .sync_o(sd_sync)
  );

  // Register state
  logic en_ff;
  logic nxt_en;
  logic load_ff;
  logic nxt_load;
  cwc_mode_type mode_ff;
  cwc_mode_type nxt_mode;
  logic [3:0] pol_ff;
  logic [3:0] nxt_pol;
  logic cs_ff;
  logic nxt_cs;
  logic [SD_W-1:0] sd_en_ff;
  logic [SD_W-1:0] nxt_sd_en;
  logic [DB_W-1:0] rising_deadband_value_ff;
  logic [DB_W-1:0] nxt_rising_deadband_value;
  logic [3:0] steer_ff;
  logic [3:0] nxt_steer;

  // Generator state
  logic data_prev_ff;
  logic nxt_data_prev;
  logic seen_fall_ff;
  logic nxt_seen_fall;
  logic [DB_W-1:0] db_work_ff;
  logic [DB_W-1:0] nxt_db_work;
  logic [3:0] steer_work_ff;
  logic [3:0] nxt_steer_work;
  logic phase_ff;
  logic nxt_phase;
  cwc_quad_type wave_ff;
  cwc_quad_type nxt_wave;
  logic sd_ff;
  logic nxt_sd;

  // Bus state
  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic [APB_DW-1:0] prdata_ff;
  logic [APB_DW-1:0] nxt_prdata;

  logic access;
  logic wr_fire;
  logic [REG_W-1:0] wbyte;
  logic data_rise;
  logic data_fall;
  logic tick;
  logic db_out;
  logic sd_now;
  cwc_quad_type raw;

  assign access = psel_i && penable_i;
  // Write lands only at the edge where pready is seen high
  assign wr_fire = access && pready_ff && pwrite_i && cwc_is_reg(paddr_i);
  assign wbyte = pwdata_i[REG_W-1:0];
  assign data_rise = data_sync && !data_prev_ff;
  assign data_fall = !data_sync && data_prev_ff;
  assign tick = cs_ff ? internal_fast_oscillator_tick_i : fosc_tick_i;
  assign sd_now = |(sd_en_ff & sd_sync);

  cwc_deadband u_deadband (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .tick_i(tick),
    .data_i(data_sync && en_ff),
    .data_rise_i(data_rise && en_ff),
    .count_i(db_work_ff),
    .delayed_o(db_out)
  );

  // Register file next state
  always_comb begin
    nxt_en = en_ff;
    nxt_load = load_ff;
    nxt_mode = mode_ff;
    nxt_pol = pol_ff;
    nxt_cs = cs_ff;
    nxt_sd_en = sd_en_ff;
    nxt_rising_deadband_value = rising_deadband_value_ff;
    nxt_steer = steer_ff;
    if (srst_i) begin
      nxt_en = 1'b0;
      nxt_load = 1'b0;
      nxt_mode = cwc_mode_type'(MODE_RST);
      nxt_pol = NIBBLE_RST;
      nxt_cs = 1'b0;
      nxt_sd_en = SD_RST;
      nxt_rising_deadband_value = DB_RST;
      nxt_steer = NIBBLE_RST;
    end else if (ce_i) begin
      // Hardware clears the load bit once the transfer happened
      if (load_ff && data_rise && seen_fall_ff) begin
        nxt_load = 1'b0;
      end
      if (!en_ff) begin
        nxt_load = 1'b0;
      end
      if (wr_fire) begin
        unique case (paddr_i)
          OFS_CONTROL_0: begin
            nxt_en = wbyte[CON0_EN_BIT];
            // Load request honoured only when enable was already set
            if (wbyte[CON0_LD_BIT] && en_ff && wbyte[CON0_EN_BIT]) begin
              nxt_load = 1'b1;
            end
            if (!wbyte[CON0_EN_BIT]) begin
              nxt_load = 1'b0;
            end
            nxt_mode = cwc_mode_type'(wbyte[CON0_MODE_LSB +: 3]);
          end
          OFS_CONTROL_1: nxt_pol = wbyte[CON1_POL_LSB +: 4];
          OFS_CLOCK_SELECT: nxt_cs = wbyte[CLK_CS_BIT];
          OFS_SHUTDOWN_EN: nxt_sd_en = wbyte[AS_LSB +: SD_W];
          OFS_RISING_DB: nxt_rising_deadband_value = wbyte[DB_LSB +: DB_W];
          OFS_STEER_STATUS: nxt_steer = wbyte[STEER_LSB +: 4];
          default: begin
          end
        endcase
      end
    end
  end

  // Waveform generation next state
  always_comb begin
    nxt_data_prev = data_prev_ff;
    nxt_seen_fall = seen_fall_ff;
    nxt_db_work = db_work_ff;
    nxt_steer_work = steer_work_ff;
    nxt_phase = phase_ff;
    nxt_wave = wave_ff;
    nxt_sd = sd_ff;
    raw = '0;
    unique case (mode_ff)
      CWC_MODE_ASYNC_STEER: raw = steer_ff & {4{data_sync}};
      CWC_MODE_SYNC_STEER: raw = steer_work_ff & {4{data_sync}};
      CWC_MODE_FWD_FULL: begin
        raw.a = 1'b1;
        raw.d = data_sync;
      end
      CWC_MODE_REV_FULL: begin
        raw.c = 1'b1;
        raw.b = data_sync;
      end
      CWC_MODE_HALF_BRIDGE: begin
        raw.a = db_out;
        raw.c = db_out;
        raw.b = !data_sync;
        raw.d = !data_sync;
      end
      CWC_MODE_PUSH_PULL: begin
        raw.a = db_out && !(phase_ff ^ data_rise);
        raw.b = db_out && (phase_ff ^ data_rise);
      end
      // Reserved codes keep every output inactive
      CWC_MODE_RSVD_6, CWC_MODE_RSVD_7: raw = '0;
    endcase
    if (srst_i) begin
      nxt_data_prev = 1'b0;
      nxt_seen_fall = 1'b0;
      nxt_db_work = DB_RST;
      nxt_steer_work = NIBBLE_RST;
      nxt_phase = 1'b0;
      nxt_wave = '0;
      nxt_sd = 1'b0;
    end else if (ce_i) begin
      nxt_data_prev = data_sync;
      // Arm on a fall seen while load is pending
      if (!load_ff) begin
        nxt_seen_fall = 1'b0;
      end else if (data_fall) begin
        nxt_seen_fall = 1'b1;
      end
      if (load_ff && seen_fall_ff && data_rise) begin
        nxt_db_work = rising_deadband_value_ff;
        nxt_seen_fall = 1'b0;
      end
      if (data_rise) begin
        nxt_steer_work = steer_ff;
        nxt_phase = !phase_ff;
      end
      nxt_sd = en_ff && sd_now;
      // Disabled or shut down: drive the inactive level for each polarity
      if (!en_ff || sd_now) begin
        nxt_wave = cwc_quad_type'(pol_ff);
      end else begin
        nxt_wave = raw ^ cwc_quad_type'(pol_ff);
      end
    end
  end

  // APB slave: pready one cycle into the access phase
  always_comb begin
    nxt_pready = pready_ff;
    nxt_pslverr = pslverr_ff;
    nxt_prdata = prdata_ff;
    if (srst_i) begin
      nxt_pready = 1'b0;
      nxt_pslverr = 1'b0;
      nxt_prdata = WORD_ZERO;
    end else if (ce_i) begin
      nxt_pready = access && !pready_ff;
      nxt_pslverr = access && !pready_ff && !cwc_is_reg(paddr_i);
      nxt_prdata = WORD_ZERO;
      if (access && !pready_ff && !pwrite_i) begin
        unique case (paddr_i)
          OFS_CONTROL_0: nxt_prdata = cwc_word({en_ff, load_ff, 3'h0, mode_ff});
          OFS_CONTROL_1: nxt_prdata = cwc_word({2'h0, data_sync, 1'b0, pol_ff});
          OFS_CLOCK_SELECT: nxt_prdata = cwc_word({7'h00, cs_ff});
          OFS_SHUTDOWN_EN: nxt_prdata = cwc_word({3'h0, sd_en_ff});
          OFS_RISING_DB: nxt_prdata = cwc_word({2'h0, rising_deadband_value_ff});
          OFS_STEER_STATUS: nxt_prdata = cwc_word({3'h0, sd_ff, steer_ff});
          default: nxt_prdata = WORD_ZERO;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    en_ff <= nxt_en;
    load_ff <= nxt_load;
    mode_ff <= nxt_mode;
    pol_ff <= nxt_pol;
    cs_ff <= nxt_cs;
    sd_en_ff <= nxt_sd_en;
    rising_deadband_value_ff <= nxt_rising_deadband_value;
    steer_ff <= nxt_steer;
  end

  always_ff @(posedge core_clk_i) begin
    data_prev_ff <= nxt_data_prev;
    seen_fall_ff <= nxt_seen_fall;
    db_work_ff <= nxt_db_work;
    steer_work_ff <= nxt_steer_work;
    phase_ff <= nxt_phase;
    wave_ff <= nxt_wave;
    sd_ff <= nxt_sd;
  end

  always_ff @(posedge core_clk_i) begin
    pready_ff <= nxt_pready;
    pslverr_ff <= nxt_pslverr;
    prdata_ff <= nxt_prdata;
  end

  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign wave_o = wave_ff;
  assign shutdown_o = sd_ff;

endmodule : cwc_top
`default_nettype wire

// *** tb/cwc_switch_model.sv ***
// Power switch stage model driven by the four waveform outputs
`timescale 1ns/1ps
`default_nettype none
module cwc_switch_model
  import cwc_pkg::*;
(
  input wire logic core_clk_i,
  input wire cwc_quad_type gate_i,
  output cwc_quad_type switch_o
);
  // Conduction follows gate drive one cycle late, like a real driver stage
  always_ff @(posedge core_clk_i) begin
    switch_o <= gate_i;
  end
endmodule : cwc_switch_model
`default_nettype wire

// *** tb/cwc_top_sva.sv ***
// Bus timing and output checks for the waveform control block
`timescale 1ns/1ps
`default_nettype none
module cwc_top_sva
  import cwc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [APB_AW-1:0] paddr_i,
  input wire logic [APB_DW-1:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire cwc_sd_type shutdown_req_i,
  input wire cwc_quad_type wave_o,
  input wire logic shutdown_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);
  logic mapped;
  assign mapped = paddr_i inside {OFS_CONTROL_0, OFS_CONTROL_1, OFS_CLOCK_SELECT,
                                  OFS_SHUTDOWN_EN, OFS_RISING_DB, OFS_STEER_STATUS};
  a_ready_timely: assert property (psel_i && $rose(penable_i) |=> pready_o)
    else $error("pready late after access phase");
  a_ready_single: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  a_ready_access: assert property (pready_o |-> psel_i && penable_i)
    else $error("pready outside access phase");
  a_ready_idle: assert property (!(psel_i && penable_i) |=> !pready_o)
    else $error("pready without request");
  a_err_decode: assert property (pready_o |-> pslverr_o == !mapped)
    else $error("pslverr does not match decode");
  a_err_data_zero: assert property (pready_o && pslverr_o |-> prdata_o == WORD_ZERO)
    else $error("read data not zero on error");
  a_upper_zero: assert property (pready_o |-> prdata_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_shutdown_cause: assert property (shutdown_o |-> (|$past(shutdown_req_i, 2)) ||
    (|$past(shutdown_req_i, 3)) || (|$past(shutdown_req_i, 4)))
    else $error("shutdown without request");
  a_reset_clear: assert property ($fell(srst_i) |-> wave_o == 4'h0 && !shutdown_o)
    else $error("outputs not cleared by reset");
endmodule : cwc_top_sva
bind cwc_top cwc_top_sva u_sva (.core_clk_i(core_clk_i), .srst_i(srst_i), .psel_i(psel_i),
  .penable_i(penable_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .shutdown_req_i(shutdown_req_i), .wave_o(wave_o),
  .shutdown_o(shutdown_o));
`default_nettype wire

// *** tb/tb_complementary_waveform_ctrl.sv ***
// Self-checking bench for the waveform control block
`timescale 1ns/1ps
`default_nettype none
module tb_complementary_waveform_ctrl
  import cwc_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [APB_AW-1:0] paddr_i = 8'h00;
  logic [APB_DW-1:0] pwdata_i = 32'h00000000;
  logic [APB_DW-1:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic fosc_tick_i = 1'b0;
  logic hf_tick_i = 1'b0;
  logic data_pin_i = 1'b0;
  cwc_sd_type shutdown_req_i = 5'h00;
  cwc_quad_type wave_o;
  cwc_quad_type switch_o;
  logic shutdown_o;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [APB_DW-1:0] rdat;
  logic rerr;
  logic [7:0] wmask [6] = '{8'h87, 8'h0f, 8'h01, 8'h1f, 8'h3f, 8'h0f};
  logic [2:0] mcode [7] = '{3'h2, 3'h3, 3'h6, 3'h7, 3'h0, 3'h1, 3'h4};
  logic [3:0] m_hi [7] = '{4'h9, 4'h6, 4'h0, 4'h0, 4'hf, 4'hf, 4'h5};
  logic [3:0] m_lo [7] = '{4'h1, 4'h4, 4'h0, 4'h0, 4'h0, 4'h0, 4'ha};
  int sbit [3] = '{SD_PIN, SD_CMP1, SD_LOGIC4};
  always #5 core_clk_i = ~core_clk_i;
  // Tick on every other cycle so the dead-band stretch is visible
  always @(posedge core_clk_i) fosc_tick_i <= ~fosc_tick_i;
  cwc_top uut (.core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(1'b1), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .fosc_tick_i(fosc_tick_i), .internal_fast_oscillator_tick_i(hf_tick_i),
    .data_pin_i(data_pin_i), .shutdown_req_i(shutdown_req_i), .wave_o(wave_o),
    .shutdown_o(shutdown_o));
  cwc_switch_model u_stage (.core_clk_i(core_clk_i), .gate_i(wave_o), .switch_o(switch_o));
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic xfer(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk_i);
      if (pready_o === 1'b1) break;
    end
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (i == 20) begin
      n_mismatch++;
      close_out();
    end
  endtask : xfer
  task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rchk(input string name, input logic [APB_AW-1:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h00000000);
    check(name, rdat, exp);
  endtask : rchk
  task automatic pin(input logic v, input int n);
    @(posedge core_clk_i);
    data_pin_i <= v;
    repeat (n) @(posedge core_clk_i);
  endtask : pin
  task automatic wchk(input string name, input logic [3:0] exp);
    check(name, {28'h0000000, switch_o}, {28'h0000000, exp});
  endtask : wchk
  initial begin
    repeat (20) @(posedge core_clk_i);
    srst_i <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      rchk("reset", 8'(4 * k), 32'h00000000);
    end
    // Enable was 0 before this write, so the load bit must not stick
    for (int k = 0; k < 6; k++) begin
      wr(8'(4 * k), 32'hffffffff);
      rchk("mask", 8'(4 * k), {24'h000000, wmask[k]});
      wr(8'(4 * k), 32'h00000000);
    end
    wr(8'h18, 32'hffffffff);
    check("wr_err", {31'h0, rerr}, 32'h00000001);
    rchk("unmapped", 8'h18, 32'h00000000);
    check("rd_err", {31'h0, rerr}, 32'h00000001);
    wr(OFS_CONTROL_1, 32'h0000000f);
    wr(OFS_CONTROL_0, 32'h00000002);
    pin(1'b1, 8);
    wchk("disabled", 4'hf);
    rchk("input", OFS_CONTROL_1, 32'h0000002f);
    wr(OFS_CONTROL_1, 32'h00000001);
    wr(OFS_CONTROL_0, 32'h00000082);
    repeat (8) @(posedge core_clk_i);
    wchk("polarity", 4'h8);
    wr(OFS_CONTROL_1, 32'h00000000);
    pin(1'b0, 8);
    wr(OFS_STEER_STATUS, 32'h0000000f);
    for (int k = 0; k < 7; k++) begin
      wr(OFS_CONTROL_0, 32'h00000080 | 32'(mcode[k]));
      pin(1'b1, 8);
      wchk("mode_hi", m_hi[k]);
      pin(1'b0, 8);
      wchk("mode_lo", m_lo[k]);
    end
    wr(OFS_CONTROL_0, 32'h00000085);
    // Ninth data rise since reset, so output B takes this half period
    pin(1'b1, 8);
    wchk("pp_first", 4'h2);
    pin(1'b0, 8);
    wchk("pp_low", 4'h0);
    pin(1'b1, 8);
    wchk("pp_second", 4'h1);
    pin(1'b0, 8);
    wr(OFS_CONTROL_0, 32'h00000082);
    pin(1'b1, 8);
    for (int k = 0; k < 3; k++) begin
      wr(OFS_SHUTDOWN_EN, 32'h00000000);
      @(posedge core_clk_i) shutdown_req_i <= 5'(1 << sbit[k]);
      repeat (8) @(posedge core_clk_i);
      check("sd_masked", {31'h0, shutdown_o}, 32'h00000000);
      wchk("sd_masked", 4'h9);
      wr(OFS_SHUTDOWN_EN, 32'(1 << sbit[k]));
      repeat (8) @(posedge core_clk_i);
      check("sd_active", {31'h0, shutdown_o}, 32'h00000001);
      wchk("sd_active", 4'h0);
      @(posedge core_clk_i) shutdown_req_i <= 5'h00;
    end
    wr(OFS_SHUTDOWN_EN, 32'h00000000);
    pin(1'b0, 8);
    wr(OFS_RISING_DB, 32'h00000004);
    wr(OFS_CLOCK_SELECT, 32'h00000001);
    wr(OFS_CONTROL_0, 32'h00000084);
    wr(OFS_CONTROL_0, 32'h000000c4);
    pin(1'b1, 8);
    rchk("load_hold", OFS_CONTROL_0, 32'h000000c4);
    pin(1'b0, 8);
    pin(1'b1, 8);
    rchk("load_done", OFS_CONTROL_0, 32'h00000084);
    // Fresh edge pair so the loaded count is in use without a race
    pin(1'b0, 8);
    pin(1'b1, 12);
    wchk("db_stall", 4'h0);
    wr(OFS_CLOCK_SELECT, 32'h00000000);
    repeat (20) @(posedge core_clk_i);
    wchk("db_run", 4'h5);
    // Fast oscillator tick now runs, so clock select 1 counts too
    pin(1'b0, 8);
    @(posedge core_clk_i) hf_tick_i <= 1'b1;
    wr(OFS_CLOCK_SELECT, 32'h00000001);
    pin(1'b1, 20);
    wchk("db_fast", 4'h5);
    // Reset in mid-run while the outputs are active
    @(posedge core_clk_i) srst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    srst_i <= 1'b0;
    rchk("mid_reset", OFS_CONTROL_0, 32'h00000000);
    rchk("mid_reset_db", OFS_RISING_DB, 32'h00000000);
    wchk("mid_reset", 4'h0);
    close_out();
  end
endmodule : tb_complementary_waveform_ctrl
`default_nettype wire
